// >>> design/adcc_conv_ctrl.sv
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Purpose: converter sequencing, register file and trigger handling
// Assumes: trigger and mode come from logic on ref_clk
// Notes: comparator, pins and fuse pass a two-stage synchroniser
module adcc_conv_ctrl
  import adcc_pkg::*;
#(
  parameter int unsigned RC_CYC = RC_TAD_CYC
) (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // axi4-lite write
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // axi4-lite read
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // compare module
  input logic [3:0] compare2_mode_field,
  input logic cmp_special_trig,
  output logic timer_clear,
  // pins and strap
  input logic portb_analog_reset_fuse,
  input logic [NUM_CH-1:0] port_pin_in,
  // analog front end
  input logic comparator_in,
  output adcc_ana_t ana_o,
  output logic conversion_done_flag
);

  typedef enum logic [1:0] {ST_SAMPLE, ST_DELAY, ST_ACQ, ST_CONV} adcc_st_t;

  logic [NUM_CH+1:0] sync1_q, sync2_q;
  logic [1:0] cfg_cnt_q;
  adcc_ctrl0_t ctrl0_q;
  adcc_ctrl1_t ctrl1_q;
  adcc_ctrl2_t ctrl2_q;
  logic [7:0] res_h_q, res_l_q;
  logic flag_q, timer_clear_q;
  logic aw_hold_q, w_hold_q, w_strb0_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q, w_data_q;
  logic [1:0] bresp_q, rresp_q;
  logic [NUM_CH-1:0] rdata_q, analog_mask;
  adcc_st_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [11:0] sar_q, sar_d;
  logic done, tad_tick;
  logic [4:0] h_acq_q, h_conv_q;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers: only sync2_q is read
  wire [NUM_CH-1:0] pins_s = sync2_q[NUM_CH-1:0];
  wire comp_s = sync2_q[NUM_CH];
  wire fuse_s = sync2_q[NUM_CH+1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {portb_analog_reset_fuse, comparator_in, port_pin_in};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus decode
  wire wr_fire = aw_hold_q && w_hold_q;
  wire wr_b = wr_fire && w_strb0_q;
  wire wr_c0 = wr_b && (aw_addr_q == OFS_CTRL0);
  wire wr_c1 = wr_b && (aw_addr_q == OFS_CTRL1);
  wire wr_c2 = wr_b && (aw_addr_q == OFS_CTRL2);
  wire wr_rh = wr_b && (aw_addr_q == OFS_RESH);
  wire wr_rl = wr_b && (aw_addr_q == OFS_RESL);
  wire wr_st = wr_b && (aw_addr_q == OFS_STAT);
  wire w_hit = (aw_addr_q <= OFS_PORT) && (aw_addr_q[1:0] == 2'h0);
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire r_hit = (s_axi_araddr <= OFS_PORT) && (s_axi_araddr[1:0] == 2'h0);
  wire [7:0] ctrl0_rd = ctrl0_q;
  wire [NUM_CH-1:0] port_rd = pins_s & ~analog_mask;
  wire [NUM_CH-1:0] rd_val =
    (s_axi_araddr == OFS_CTRL0) ? {5'h00, ctrl0_rd} :
    (s_axi_araddr == OFS_CTRL1) ? {5'h00, ctrl1_q} :
    (s_axi_araddr == OFS_CTRL2) ? {5'h00, ctrl2_q} :
    (s_axi_araddr == OFS_RESH) ? {5'h00, res_h_q} :
    (s_axi_araddr == OFS_RESL) ? {5'h00, res_l_q} :
    (s_axi_araddr == OFS_STAT) ? {12'h000, flag_q} :
    (s_axi_araddr == OFS_PORT) ? port_rd : '0;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {{(32 - NUM_CH){1'b0}}, rdata_q};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog pin mask: channel i is analog while i + port_cfg < 15
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_mask
    assign analog_mask[gi] =
      (5'(gi) + {1'b0, ctrl1_q.port_cfg}) < PORT_ANALOG_CONFIG_ANALOG_LIM;
  end

  ////////////////////////////////////////////////////////////////////////
  // start bit, trigger and flag
  wire trig_mode = cmp_special_trig && (compare2_mode_field == CMP_TRIG_MODE);
  wire trig_hit = trig_mode && ctrl0_q.enable;
  wire go_set = trig_hit || (wr_c0 && w_data_q[1]);
  wire go_clr = done || (wr_c0 && !w_data_q[1]);
  wire flag_clr = wr_st && !w_data_q[0];
  wire rc_sel = (ctrl2_q.clk_sel[1:0] == 2'h3);
  wire [4:0] acq_n = acq_tads(ctrl2_q.acq);
  wire start = (st_q == ST_SAMPLE) && ctrl0_q.go && ctrl0_q.enable;
  wire abort = (st_q != ST_SAMPLE) && !(ctrl0_q.go && ctrl0_q.enable);
  wire [11:0] trial = SAR_FIRST >> (cnt_q - 5'h01);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= '0;
      flag_q <= 1'b0;
      timer_clear_q <= 1'b0;
    end else begin
      if (wr_c0) begin
        ctrl0_q.chan <= w_data_q[5:2];
        ctrl0_q.enable <= w_data_q[0];
      end
      // a set in the same cycle as a clear wins
      if (go_set) begin
        ctrl0_q.go <= 1'b1;
      end else if (go_clr) begin
        ctrl0_q.go <= 1'b0;
      end
      if (done) begin
        flag_q <= 1'b1;
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
      timer_clear_q <= trig_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration and result registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_cnt_q <= '0;
      ctrl1_q <= '0;
      ctrl2_q <= '0;
      res_h_q <= '0;
      res_l_q <= '0;
    end else begin
      if (cfg_cnt_q != 2'h3) begin
        cfg_cnt_q <= cfg_cnt_q + 2'h1;
      end
      // fuse is sampled once it has passed the synchroniser
      if (cfg_cnt_q == CFG_LOAD_AT) begin
        ctrl1_q.port_cfg <= fuse_s ? PORT_ANALOG_CONFIG_RST_FUSE1 : PORT_ANALOG_CONFIG_RST_FUSE0;
      end else if (wr_c1) begin
        ctrl1_q.port_cfg <= w_data_q[3:0];
      end
      if (wr_c1) begin
        ctrl1_q.ref_sel <= w_data_q[5:4];
      end
      if (wr_c2) begin
        ctrl2_q <= {w_data_q[7], 1'b0, w_data_q[5:0]};
      end
      if (done) begin
        res_h_q <= ctrl2_q.justify ? {4'h0, sar_d[11:8]} : sar_d[11:4];
        res_l_q <= ctrl2_q.justify ? sar_d[7:0] : {sar_d[3:0], 4'h0};
      end else begin
        if (wr_rh) begin
          res_h_q <= w_data_q;
        end
        if (wr_rl) begin
          res_l_q <= w_data_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: sample, optional delay, acquisition, conversion
  adcc_tad_gen #(
    .RC_CYC(RC_CYC)
  ) u_tad (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run((st_q == ST_ACQ) || (st_q == ST_CONV)),
    .clk_sel(ctrl2_q.clk_sel),
    .tad_tick(tad_tick)
  );

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sar_d = sar_q;
    done = 1'b0;
    if (abort) begin
      st_d = ST_SAMPLE;
      cnt_d = '0;
    end else begin
      case (st_q)
        ST_SAMPLE: begin
          cnt_d = '0;
          if (start && rc_sel && (acq_n == 5'h00)) begin
            st_d = ST_DELAY;
          end else if (start && (acq_n != 5'h00)) begin
            st_d = ST_ACQ;
          end else if (start) begin
            st_d = ST_CONV;
          end
        end
        ST_DELAY: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == TCY_LAST) begin
            st_d = ST_CONV;
            cnt_d = '0;
          end
        end
        ST_ACQ: begin
          if (tad_tick && (cnt_q == acq_n - 5'h01)) begin
            st_d = ST_CONV;
            cnt_d = '0;
          end else if (tad_tick) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'h00) begin
              sar_d = SAR_FIRST;
            end else begin
              sar_d = (comp_s ? sar_q : (sar_q & ~trial)) | (trial >> 1);
            end
            if (cnt_q == CONV_LAST) begin
              st_d = ST_SAMPLE;
              cnt_d = '0;
              done = 1'b1;
            end
          end
        end
        default: begin
          st_d = ST_SAMPLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_SAMPLE;
      cnt_q <= '0;
      sar_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sar_q <= sar_d;
    end
  end

  // the mux follows the channel bits whatever the pin configuration
  assign ana_o = '{sample_en: (st_q != ST_CONV),
                   chan: ctrl0_q.chan,
                   ref_sel: ctrl1_q.ref_sel,
                   dac_code: sar_q};
  assign timer_clear = timer_clear_q;
  assign conversion_done_flag = flag_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_acq_q <= '0;
      h_conv_q <= '0;
    end else begin
      h_acq_q <= (st_q == ST_ACQ) ? h_acq_q + {4'h0, tad_tick} : '0;
      h_conv_q <= (st_q == ST_CONV) ? h_conv_q + {4'h0, tad_tick} : '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_done_seen;
    !ctrl0_q.go && flag_q && (st_q == ST_SAMPLE);
  endsequence

  property p_trig_go;
    trig_hit |=> ctrl0_q.go;
  endproperty
  a_trig_go: assert property (p_trig_go)
    else $error("trigger did not set start bit");

  property p_timer_clr;
    trig_mode |=> timer_clear;
  endproperty
  a_timer_clr: assert property (p_timer_clr)
    else $error("trigger did not clear timer");

  property p_trig_off;
    trig_mode && !ctrl0_q.enable && !ctrl0_q.go && !wr_c0
      |=> !ctrl0_q.go && timer_clear;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("disabled converter reacted to trigger");

  property p_rc_delay;
    (st_q == ST_CONV) && ($past(st_q) == ST_DELAY)
      |-> ($past(st_q, 4) == ST_DELAY) && ($past(st_q, 5) == ST_SAMPLE);
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("start delay not one instruction cycle");

  property p_acq_len;
    (st_q == ST_CONV) && ($past(st_q) == ST_ACQ)
      |-> h_acq_q == $past(acq_n);
  endproperty
  a_acq_len: assert property (p_acq_len)
    else $error("acquisition count mismatch");

  property p_conv_len;
    (st_q == ST_SAMPLE) && ($past(st_q) == ST_CONV) && $past(ctrl0_q.go)
      && $past(ctrl0_q.enable) |-> h_conv_q == CONV_TADS;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion not thirteen periods");

  property p_done;
    done && !go_set |=> s_done_seen;
  endproperty
  a_done: assert property (p_done)
    else $error("completion did not clear start or set flag");

  property p_result;
    done |=> (res_l_q[3:0] == ($past(ctrl2_q.justify) ?
               $past(sar_d[3:0]) : 4'h0))
             && (res_h_q[3:0] == ($past(ctrl2_q.justify) ?
               $past(sar_d[11:8]) : $past(sar_d[7:4])));
  endproperty
  a_result: assert property (p_result)
    else $error("result not loaded with selected justification");

  property p_port_mask;
    ar_fire && (s_axi_araddr == OFS_PORT)
      |=> (rdata_q & $past(analog_mask)) == '0;
  endproperty
  a_port_mask: assert property (p_port_mask)
    else $error("analog pin read back nonzero");

endmodule // adcc_conv_ctrl

// >>> design/adcc_pkg.sv
// Purpose: constants and types for the converter control block
// Assumes: ref_clk at 200 MHz, one oscillator period per ref_clk cycle
// Notes: offsets are byte addresses on the AXI4-Lite register port
// How it works
// - clock select code sets conversion clock period
// - rc clock, zero acquisition delays one instruction cycle
// - selected pin sampled whatever its configuration
// - analog configured pins read back as zero
// - compare trigger sets start bit when enabled
// - every compare trigger clears the timer
// - disabled converter ignores trigger, timer still cleared
// - port config reset value follows the fuse
// - programmed acquisition count precedes automatic conversion
// - conversion lasts thirteen conversion clock periods
// - completion clears start, sets flag, resamples
package adcc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RC_TAD_NS = 2500;
  localparam int unsigned RC_TAD_CYC = (RC_TAD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TCY_TOSC = 4;
  localparam logic [4:0] TCY_LAST = 5'(TCY_TOSC - 1);
  localparam logic [4:0] CONV_LAST = 5'h0C;
  localparam logic [4:0] CONV_TADS = 5'h0D;
  localparam int unsigned NUM_CH = 13;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_RESH = 8'h0C;
  localparam logic [7:0] OFS_RESL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;

  // reset values and codes
  localparam logic [3:0] PORT_ANALOG_CONFIG_RST_FUSE1 = 4'h0;
  localparam logic [3:0] PORT_ANALOG_CONFIG_RST_FUSE0 = 4'h7;
  localparam logic [1:0] CFG_LOAD_AT = 2'h2;
  localparam logic [3:0] CMP_TRIG_MODE = 4'hB;
  localparam logic [4:0] PORT_ANALOG_CONFIG_ANALOG_LIM = 5'h0F;
  localparam logic [11:0] SAR_FIRST = 12'h800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] rsv;
    logic [3:0] chan;
    logic go;
    logic enable;
  } adcc_ctrl0_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] ref_sel;
    logic [3:0] port_cfg;
  } adcc_ctrl1_t;

  typedef struct packed {
    logic justify;
    logic rsv;
    logic [2:0] acq;
    logic [2:0] clk_sel;
  } adcc_ctrl2_t;

  typedef struct packed {
    logic sample_en;
    logic [3:0] chan;
    logic [1:0] ref_sel;
    logic [11:0] dac_code;
  } adcc_ana_t;

  // oscillator periods per conversion clock, rc codes unused here
  function automatic logic [6:0] tad_tosc(input logic [2:0] sel);
    case (sel)
      3'h0: tad_tosc = 7'h02;
      3'h4: tad_tosc = 7'h04;
      3'h1: tad_tosc = 7'h08;
      3'h5: tad_tosc = 7'h10;
      3'h2: tad_tosc = 7'h20;
      3'h6: tad_tosc = 7'h40;
      default: tad_tosc = 7'h02;
    endcase
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

endpackage

// >>> design/adcc_tad_gen.sv
`timescale 1ns/1ps
// Purpose: conversion clock enable from oscillator divider or rc timer
// Assumes: run drops between conversions, restarting the phase
// Notes: the rc oscillator is modelled as a fixed ref_clk count
module adcc_tad_gen
  import adcc_pkg::*;
#(
  parameter int unsigned RC_CYC = RC_TAD_CYC
) (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // control
  input logic run,
  input logic [2:0] clk_sel,
  // conversion clock enable
  output logic tad_tick
);

  localparam int CW = (RC_CYC > 64) ? $clog2(RC_CYC) : 7;

  logic [CW-1:0] cnt_q;
  wire rc_sel = (clk_sel[1:0] == 2'h3);
  wire [CW-1:0] last = rc_sel ? CW'(RC_CYC - 1) :
                       CW'(tad_tosc(clk_sel) - 7'h01);

  assign tad_tick = run && (cnt_q == last);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!run || tad_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule // adcc_tad_gen

// >>> bench/adcc_afe_model.sv
// Purpose: analog pins and comparator facing the converter control
// Assumes: pin level of channel c is {c, 8'hA5} in result codes
// Notes: the comparator judges the held sample, not the live pin
`timescale 1ns/1ps
module adcc_afe_model
  import adcc_pkg::*;
(
  // clock
  input logic ref_clk,
  // converter side
  input adcc_ana_t ana_o,
  output logic comparator_in,
  output logic [NUM_CH-1:0] port_pin_in
);
  logic [11:0] held_q;

  //////////////////////////////////////////////////////////////////////////
  // track the pin while sampling, freeze it while converting
  always_ff @(posedge ref_clk) begin
    if (ana_o.sample_en) begin
      held_q <= {ana_o.chan, 8'hA5};
    end
  end

  // a level at or above the trial code keeps the bit
  assign comparator_in = (held_q >= ana_o.dac_code);
  // pins idle high so that analog masking shows up as zero
  assign port_pin_in = {NUM_CH{1'b1}};
endmodule // adcc_afe_model

// >>> bench/adcc_conv_ctrl_tb_top.sv
// Purpose: register level tests of the converter control block
// Assumes: fuse 0, then 1 for a mid-run reset; rc clock shortened to 8 cycles
// Notes: conversion times are checked to the cycle against the tick count
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module adcc_conv_ctrl_tb_top
  import adcc_pkg::*;
;
  localparam int unsigned RCC = 8;
  logic ref_clk = 0, rst_n = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, tclr, flag, cmp;
  logic [1:0] bresp, rresp, r;
  logic [3:0] mode = 0;
  logic trig = 0;
  logic fuse = 0;
  logic [NUM_CH-1:0] pins;
  adcc_ana_t ana;
  logic [31:0] d;
  int miscompares = 0, checked = 0, dur;
  int tadv[8] = '{2, 8, 32, RCC, 4, 16, 64, RCC};

  adcc_conv_ctrl #(.RC_CYC(RCC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare2_mode_field(mode), .cmp_special_trig(trig),
    .timer_clear(tclr), .portb_analog_reset_fuse(fuse),
    .port_pin_in(pins), .comparator_in(cmp), .ana_o(ana),
    .conversion_done_flag(flag));
  adcc_afe_model i_afe (.ref_clk(ref_clk), .ana_o(ana),
    .comparator_in(cmp), .port_pin_in(pins));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic bdone;
    bdone = 0;
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1; wdata <= {24'h0, v}; wvalid <= 1; bready <= 1;
    while (!bdone) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        bready <= 0; r = bresp; bdone = 1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic rdone;
    rdone = 0;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!rdone) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        rready <= 0; d = rdata; r = rresp; rdone = 1;
      end
    end
  endtask

  task automatic wait_done(input int lim);
    dur = 0;
    while (flag !== 1'b1 && dur < lim) begin
      @(posedge ref_clk);
      dur++;
    end
  endtask

  // one software started conversion on channel 5, then flag cleared
  task automatic conv(input logic [7:0] c2, input int e);
    wr(OFS_CTRL2, c2);
    wr(OFS_CTRL0, 8'h17);
    // bus stays quiet until the flag, as a core left asleep would
    wait_done(3000);
    // the loop sees the flag one edge after the edge that sets it
    `CHK("conv time", e + 1, dur)
    rd(OFS_CTRL0); `CHK("go", 1'b0, d[1])
    rd(OFS_STAT); `CHK("done flag", 1'b1, d[0])
    wr(OFS_STAT, 8'h00);
  endtask

  task automatic pulse(input logic [3:0] m, input logic te);
    mode <= m;
    @(posedge ref_clk); trig <= 1;
    @(posedge ref_clk); trig <= 0;
    @(posedge ref_clk); `CHK("timer clear", te, tclr)
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    repeat (4) @(posedge ref_clk);
    rd(OFS_CTRL1); `CHK("ctrl1 reset", 32'h07, d)
    rd(OFS_PORT); `CHK("port analog", 32'h1F00, d)
    wr(OFS_CTRL1, 8'h2F);
    `CHK("ref sel", 2'h2, ana.ref_sel)
    rd(OFS_PORT); `CHK("port digital", 32'h1FFF, d)
    rd(OFS_CTRL2); `CHK("ctrl2 reset", 32'h00, d)
    wr(8'h1C, 8'h55); `CHK("wr resp", RESP_SLVERR, r)
    rd(8'h1C); `CHK("rd resp", RESP_SLVERR, r)
    // every clock select code, rc ones carry the start delay
    // rc codes model a sleeping core with idle select already cleared
    for (int c = 0; c < 8; c++) begin
      conv(8'(c), 13 * tadv[c] + ((c % 4 == 3) ? 4 : 0));
    end
    conv(8'h38, 33 * 2);
    conv(8'h3B, 33 * RCC);
    // divide by 8 keeps the comparator lag well inside one period
    for (int j = 0; j < 2; j++) begin
      conv(j ? 8'h81 : 8'h01, 13 * 8);
      rd(OFS_RESH); `CHK("res high", j ? 32'h05 : 32'h5A, d)
      rd(OFS_RESL); `CHK("res low", j ? 32'hA5 : 32'h50, d)
    end
    // channel chosen and acquisition timed before any trigger
    wr(OFS_CTRL2, 8'h09);
    wr(OFS_CTRL0, 8'h15);
    pulse(CMP_TRIG_MODE, 1'b1);
    wait_done(1000); `CHK("trig flag", 1'b1, flag)
    wr(OFS_STAT, 8'h00);
    pulse(4'h2, 1'b0);
    wr(OFS_CTRL0, 8'h14);
    pulse(CMP_TRIG_MODE, 1'b1);
    repeat (400) @(posedge ref_clk);
    `CHK("ignored flag", 1'b0, flag)
    rd(OFS_CTRL0); `CHK("ignored go", 32'h14, d)
    // second reset with the strap flipped: shared pins come up analog
    fuse <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(OFS_CTRL1); `CHK("ctrl1 fuse", 32'h00, d)
    rd(OFS_PORT); `CHK("port all analog", 32'h0000, d)
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule // adcc_conv_ctrl_tb_top
